// ==== design/efm_top.sv ====
/*
 Encoder feedback block of a servo drive: latches the settings once after
 reset, raises the type mismatch alarm, keeps the single-turn position and
 multiturn count, and divides encoder counts into quadrature A/B plus the
 index pulse. Assumes one step pulse per count with a direction level
 steady around it, at most one step per three clocks, settings on ref_clk.
*/
`timescale 1ns/10ps
module efm_top
#(
   parameter int POS_W = 16
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic encoder_type_select,
   input wire logic [efm_pkg::MT_W-1:0] multiturn_wrap_limit,
   input wire logic [efm_pkg::PPR_W-1:0] feedback_pulses_per_rev,
   input wire logic enc_step,
   input wire logic enc_dir,
   input wire logic enc_index,
   input wire logic enc_fitted_incremental,
   input wire logic enc_multiturn_capable,
   output logic quadrature_out_a,
   output logic quadrature_out_b,
   output logic index_pulse_out,
   output logic [efm_pkg::MT_W-1:0] multiturn_count,
   output logic [POS_W-1:0] single_turn_pos,
   output logic encoder_alarm,
   output logic absolute_mode,
   output logic feedback_ready
);

   localparam int ACC_W = POS_W + 2;
   // Encoder counts per revolution, one above the top position.
   localparam logic [ACC_W-1:0] CPR = {2'b01, {POS_W{1'b0}}};

   // Out-of-range settings are pulled to the nearest legal value.
   function automatic logic [efm_pkg::PPR_W-1:0] clamp_ppr(
      logic [efm_pkg::PPR_W-1:0] v);
      logic [efm_pkg::PPR_W-1:0] r;
      r = v;
      if (v < efm_pkg::PPR_MIN)
         r = efm_pkg::PPR_MIN;
      else if (v > efm_pkg::PPR_MAX)
         r = efm_pkg::PPR_MAX;
      return r;
   endfunction

   logic [efm_pkg::PIN_N-1:0] meta_r;
   logic [efm_pkg::PIN_N-1:0] pin_r;
   logic step_prev_r;
   logic step_evt;
   logic index_r;
   efm_pkg::efm_state_e st_r;
   efm_pkg::efm_state_e st_nxt;
   logic [1:0] settle_r;
   logic [1:0] settle_nxt;
   logic abs_r;
   logic abs_nxt;
   logic multi_r;
   logic multi_nxt;
   logic alarm_r;
   logic alarm_nxt;
   logic [efm_pkg::MT_W-1:0] wrap_r;
   logic [efm_pkg::MT_W-1:0] wrap_nxt;
   logic [efm_pkg::PPR_W-1:0] ppr_r;
   logic [efm_pkg::PPR_W-1:0] ppr_nxt;
   logic [POS_W-1:0] pos_r;
   logic [POS_W-1:0] pos_nxt;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_nxt;
   logic [ACC_W-1:0] inc;
   logic [ACC_W-1:0] acc_sum;
   efm_pkg::efm_quad_t quad_r;
   efm_pkg::efm_quad_t quad_nxt;
   logic zc_fwd_r;
   logic zc_fwd_nxt;
   logic zc_rev_r;
   logic zc_rev_nxt;
   efm_mt_if mt_if ();
   default clocking efm_top_cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // Two-stage synchronisers for every encoder pin; only pin_r is read.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= '0;
         pin_r <= '0;
         step_prev_r <= 1'b0;
         index_r <= 1'b0;
      end
      else
      begin
         meta_r <= {enc_multiturn_capable, enc_fitted_incremental,
            enc_index, enc_dir, enc_step};
         pin_r <= meta_r;
         step_prev_r <= pin_r[efm_pkg::PIN_STEP];
         index_r <= pin_r[efm_pkg::PIN_INDEX];
      end
   end

   assign step_evt = pin_r[efm_pkg::PIN_STEP] & ~step_prev_r;
   // Start-up: wait for the pins to settle, then latch the settings once.
   // Later changes of the setting ports are ignored until the next reset.
   always_comb
   begin
      st_nxt = st_r;
      settle_nxt = settle_r;
      abs_nxt = abs_r;
      multi_nxt = multi_r;
      alarm_nxt = alarm_r;
      wrap_nxt = wrap_r;
      ppr_nxt = ppr_r;
      unique case (st_r)
         efm_pkg::EFM_ST_LOAD:
         begin
            settle_nxt = settle_r + 1'b1;
            if (settle_r == efm_pkg::SETTLE_CYC)
            begin
               st_nxt = efm_pkg::EFM_ST_RUN;
               abs_nxt = encoder_type_select == efm_pkg::ENC_ABSOLUTE;
               multi_nxt = pin_r[efm_pkg::PIN_MULTI];
               wrap_nxt = multiturn_wrap_limit;
               ppr_nxt = clamp_ppr(feedback_pulses_per_rev);
               alarm_nxt = abs_nxt & pin_r[efm_pkg::PIN_FIT_INC];
            end
         end
         efm_pkg::EFM_ST_RUN:
            st_nxt = efm_pkg::EFM_ST_RUN;
         default:
            st_nxt = efm_pkg::EFM_ST_LOAD;
      endcase
   end

   // Settings and alarm registers; the alarm stays up until reset.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r <= efm_pkg::EFM_ST_LOAD;
         settle_r <= '0;
         abs_r <= 1'b1;
         multi_r <= 1'b0;
         alarm_r <= 1'b0;
         wrap_r <= efm_pkg::WRAP_DEFAULT;
         ppr_r <= efm_pkg::PPR_DEFAULT;
      end
      else
      begin
         st_r <= st_nxt;
         settle_r <= settle_nxt;
         abs_r <= abs_nxt;
         multi_r <= multi_nxt;
         alarm_r <= alarm_nxt;
         wrap_r <= wrap_nxt;
         ppr_r <= ppr_nxt;
      end
   end

   // Four quadrature edges per output pulse; the accumulator spreads them
   // evenly over the counts of one revolution.
   assign inc = ACC_W'({ppr_r, 2'b00});
   assign acc_sum = acc_r + inc;
   // Position and divider. Direction comes only from the synchronised encoder direction pin.
   always_comb
   begin
      pos_nxt = pos_r;
      acc_nxt = acc_r;
      quad_nxt = quad_r;
      zc_fwd_nxt = 1'b0;
      zc_rev_nxt = 1'b0;
      if (st_r == efm_pkg::EFM_ST_RUN && step_evt)
      begin
         if (pin_r[efm_pkg::PIN_DIR])
         begin
            pos_nxt = pos_r + 1'b1;
            zc_fwd_nxt = (pos_r == '1);
            if (acc_sum >= CPR)
            begin
               acc_nxt = acc_sum - CPR;
               quad_nxt = efm_pkg::efm_quad_step(quad_r, 1'b1);
            end
            else
               acc_nxt = acc_sum;
         end
         else
         begin
            pos_nxt = pos_r - 1'b1;
            zc_rev_nxt = (pos_r == '0);
            if (acc_r >= inc)
               acc_nxt = acc_r - inc;
            else
            begin
               acc_nxt = acc_r + CPR - inc;
               quad_nxt = efm_pkg::efm_quad_step(quad_r, 1'b0);
            end
         end
      end
   end

   // Position, divider and quadrature registers.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pos_r <= '0;
         acc_r <= '0;
         quad_r <= 2'b00;
         zc_fwd_r <= 1'b0;
         zc_rev_r <= 1'b0;
      end
      else
      begin
         pos_r <= pos_nxt;
         acc_r <= acc_nxt;
         quad_r <= quad_nxt;
         zc_fwd_r <= zc_fwd_nxt;
         zc_rev_r <= zc_rev_nxt;
      end
   end

   // Crossings and latched settings go to the multiturn counter.
   assign mt_if.step_fwd = zc_fwd_r;
   assign mt_if.step_rev = zc_rev_r;
   assign mt_if.abs_mode = abs_r;
   assign mt_if.multi_capable = multi_r;
   assign mt_if.wrap_limit = wrap_r;
   efm_mt_counter u_mt
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .mt(mt_if.cnt)
   );
   // All outputs are register bits.
   assign quadrature_out_a = quad_r[1];
   assign quadrature_out_b = quad_r[0];
   assign index_pulse_out = index_r;
   assign multiturn_count = mt_if.count;
   assign single_turn_pos = pos_r;
   assign encoder_alarm = alarm_r;
   assign absolute_mode = abs_r;
   assign feedback_ready = st_r[1];

   sequence latch_mismatch_s;
      st_r == efm_pkg::EFM_ST_LOAD && settle_r == efm_pkg::SETTLE_CYC
         && encoder_type_select == efm_pkg::ENC_ABSOLUTE
         && pin_r[efm_pkg::PIN_FIT_INC];
   endsequence

   alarm_raise_a: assert property (latch_mismatch_s
      |=> encoder_alarm ##1 encoder_alarm)
      else $error("mismatch alarm not raised at start-up");
   cfg_frozen_a: assert property (st_r == efm_pkg::EFM_ST_RUN
      ##1 st_r == efm_pkg::EFM_ST_RUN
      |-> $stable(abs_r) && $stable(ppr_r) && $stable(wrap_r))
      else $error("settings changed without a restart");
   index_pass_a: assert property (st_r == efm_pkg::EFM_ST_RUN
      |-> index_pulse_out == $past(enc_index, efm_pkg::INDEX_LAT))
      else $error("index output does not follow the encoder index");
   quad_gray_a: assert property ($changed(quad_r)
      |-> $onehot(quad_r ^ $past(quad_r)))
      else $error("both phases changed in one step");
   quad_dir_a: assert property ($changed(quad_r)
      && $past(pin_r[efm_pkg::PIN_DIR])
      |-> quad_r == efm_pkg::efm_quad_step($past(quad_r), 1'b1))
      else $error("phase A does not lead turning forward");
   rev_ppr_a: assert property (st_r == efm_pkg::EFM_ST_RUN
      && pos_r == '0 |-> acc_r == '0)
      else $error("pulse count per revolution is not exact");
   zero_cross_a: assert property (st_r == efm_pkg::EFM_ST_RUN
      && step_evt && pin_r[efm_pkg::PIN_DIR] && pos_r == '1
      |=> zc_fwd_r ##1 !zc_fwd_r)
      else $error("forward zero crossing not signalled once");
   hold_ready_a: assert property (st_r == efm_pkg::EFM_ST_RUN
      && !abs_r ##2 1'b1 |-> multiturn_count == '0)
      else $error("multiturn count moved in incremental mode");

endmodule

// ==== inc/efm_pkg.sv ====
/*
 Shared constants, types and helpers of the encoder feedback block:
 encoder modes, multiturn and divider setting limits, start-up timing,
 the start-up state encoding and the quadrature stepping function.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package efm_pkg;

   // Widths of the multiturn count and of the pulses-per-revolution setting.
   localparam int MT_W = 16;
   localparam int PPR_W = 16;

   // Encoder-type selection codes.
   localparam logic ENC_ABSOLUTE = 1'b0;
   localparam logic ENC_INCREMENTAL = 1'b1;

   // Multiturn wrap limit in revolutions; the default disables wrapping.
   localparam logic [MT_W-1:0] WRAP_DEFAULT = 16'h000A;

   // Feedback pulses per revolution, range and default.
   localparam logic [PPR_W-1:0] PPR_MIN = 16'h0010;
   localparam logic [PPR_W-1:0] PPR_MAX = 16'h4000;
   localparam logic [PPR_W-1:0] PPR_DEFAULT = 16'h4000;

   // Cycles waited after reset so that synchronised pins have settled.
   localparam logic [1:0] SETTLE_CYC = 2'h3;

   // Latency from the index pin to the index output, in clock cycles.
   localparam int INDEX_LAT = 3;

   // Bit positions of the synchronised pin vector.
   localparam int PIN_STEP = 0;
   localparam int PIN_DIR = 1;
   localparam int PIN_INDEX = 2;
   localparam int PIN_FIT_INC = 3;
   localparam int PIN_MULTI = 4;
   localparam int PIN_N = 5;

   // Start-up sequencer states.
   typedef enum logic [1:0]
   {
      EFM_ST_LOAD = 2'b01,
      EFM_ST_RUN = 2'b10
   } efm_state_e;

   // Quadrature state, bit 1 is phase A and bit 0 is phase B.
   typedef logic [1:0] efm_quad_t;

   // Forward walks 00, 10, 11, 01 so that phase A leads phase B.
   function automatic efm_quad_t efm_quad_step(efm_quad_t q, logic fwd);
      efm_quad_t r;
      r = q;
      unique case (q)
         2'b00: r = fwd ? 2'b10 : 2'b01;
         2'b10: r = fwd ? 2'b11 : 2'b00;
         2'b11: r = fwd ? 2'b01 : 2'b10;
         2'b01: r = fwd ? 2'b00 : 2'b11;
      endcase
      return r;
   endfunction

endpackage

// ==== inc/efm_mt_if.sv ====
/*
 Carrier between the feedback top and its multiturn counter: revolution
 crossing pulses, latched settings and the count coming back.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface efm_mt_if;
   logic step_fwd;
   logic step_rev;
   logic abs_mode;
   logic multi_capable;
   logic [efm_pkg::MT_W-1:0] wrap_limit;
   logic [efm_pkg::MT_W-1:0] count;

   // The top raises crossings; the counter answers with the count.
   modport ctl (output step_fwd, step_rev, abs_mode, multi_capable,
      wrap_limit, input count);
   modport cnt (input step_fwd, step_rev, abs_mode, multi_capable,
      wrap_limit, output count);
endinterface

// ==== design/efm_mt_counter.sv ====
/*
 Multiturn revolution counter. Steps on one-cycle crossing pulses and
 wraps at any configured limit but the default while the encoder is used as absolute and multiturn capable.
 Assumes settings on the carrier stay stable after start-up.
*/
`timescale 1ns/10ps
module efm_mt_counter
(
   input wire logic ref_clk,
   input wire logic reset_n,
   efm_mt_if.cnt mt
);

   logic [efm_pkg::MT_W-1:0] count_r;
   logic [efm_pkg::MT_W-1:0] count_nxt;
   logic wrap_on;
   logic [efm_pkg::MT_W-1:0] top_val;
   default clocking efm_mt_cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // With the default limit the count simply rolls over its full width.
   assign wrap_on = (mt.wrap_limit != efm_pkg::WRAP_DEFAULT);
   assign top_val = mt.wrap_limit - 1'b1;
   assign mt.count = count_r;

   // Next count; holding at zero wins over any crossing.
   always_comb
   begin
      count_nxt = count_r;
      if (!mt.abs_mode || !mt.multi_capable)
      begin
         count_nxt = '0;
      end
      else if (mt.step_fwd)
      begin
         if (wrap_on && count_r == top_val)
            count_nxt = '0;
         else
            count_nxt = count_r + 1'b1;
      end
      else if (mt.step_rev)
      begin
         if (wrap_on && count_r == '0)
            count_nxt = top_val;
         else
            count_nxt = count_r - 1'b1;
      end
   end

   // Count register.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= '0;
      else
         count_r <= count_nxt;
   end

   sequence fwd_at_top_s;
      mt.abs_mode && mt.multi_capable && wrap_on && mt.step_fwd
         && count_r == top_val;
   endsequence

   sequence rev_at_zero_s;
      mt.abs_mode && mt.multi_capable && wrap_on && mt.step_rev
         && count_r == '0;
   endsequence

   fwd_wrap_a: assert property (fwd_at_top_s
      |=> count_r == '0)
      else $error("forward crossing at top did not wrap to zero");

   rev_wrap_a: assert property (rev_at_zero_s
      |=> count_r == $past(top_val))
      else $error("reverse crossing at zero did not load limit minus one");

   hold_zero_a: assert property ((!mt.abs_mode || !mt.multi_capable)
      [*2] |-> count_r == '0)
      else $error("count not held at zero in incremental or single-turn");

   count_step_a: assert property (mt.abs_mode
      && mt.multi_capable && !wrap_on && mt.step_fwd
      |=> count_r == $past(count_r) + 1'b1)
      else $error("forward crossing did not add one");

endmodule

// ==== dv/efm_host_model.sv ====
/*
 Model of the host controller that reads the quadrature feedback: it
 decodes phase A and phase B into a signed edge count and counts any
 step that jumps two states at once.
 Assumes A and B are registered outputs on ref_clk.
*/
`timescale 1ns/10ps
module efm_host_model
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic quad_a,
   input wire logic quad_b,
   output int edge_pos,
   output int bad_steps
);
   logic [1:0] last_r;

   // Place of a {A,B} state in the forward walk 00, 10, 11, 01.
   function automatic int phase_idx(logic [1:0] q);
      case (q)
         2'b00: return 0;
         2'b10: return 1;
         2'b11: return 2;
         default: return 3;
      endcase
   endfunction

   // A move of one place forward counts up, back counts down, and a jump
   // of two places is a broken quarter-period spacing.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         last_r <= 2'b00;
         edge_pos <= 0;
         bad_steps <= 0;
      end
      else
      begin
         last_r <= {quad_a, quad_b};
         case ((phase_idx({quad_a, quad_b}) - phase_idx(last_r) + 4) % 4)
            1: edge_pos <= edge_pos + 1;
            3: edge_pos <= edge_pos - 1;
            2: bad_steps <= bad_steps + 1;
            default: ;
         endcase
      end
   end
endmodule

// ==== dv/tb.sv ====
/*
 Self-checking bench of the encoder feedback block: restarts with
 chosen settings, turns the encoder, and compares count, alarm, mode,
 index and the host's decoded quadrature position with expectations.
 Assumes POS_W of 8, so one revolution is 256 encoder counts.
*/
`timescale 1ns/10ps
module tb;
   logic ref_clk;
   logic reset_n;
   logic encoder_type_select;
   logic [efm_pkg::MT_W-1:0] multiturn_wrap_limit;
   logic [efm_pkg::PPR_W-1:0] feedback_pulses_per_rev;
   logic enc_step;
   logic enc_dir;
   logic enc_index;
   logic enc_fitted_incremental;
   logic enc_multiturn_capable;
   logic quadrature_out_a;
   logic quadrature_out_b;
   logic index_pulse_out;
   logic [efm_pkg::MT_W-1:0] multiturn_count;
   logic [7:0] single_turn_pos;
   logic encoder_alarm;
   logic absolute_mode;
   logic feedback_ready;
   int edge_pos;
   int bad_steps;
   int fail_count;
   int num_checks;

   efm_top #(.POS_W(8)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .encoder_type_select(encoder_type_select),
      .multiturn_wrap_limit(multiturn_wrap_limit),
      .feedback_pulses_per_rev(feedback_pulses_per_rev),
      .enc_step(enc_step), .enc_dir(enc_dir), .enc_index(enc_index),
      .enc_fitted_incremental(enc_fitted_incremental),
      .enc_multiturn_capable(enc_multiturn_capable),
      .quadrature_out_a(quadrature_out_a),
      .quadrature_out_b(quadrature_out_b),
      .index_pulse_out(index_pulse_out), .multiturn_count(multiturn_count),
      .single_turn_pos(single_turn_pos), .encoder_alarm(encoder_alarm),
      .absolute_mode(absolute_mode), .feedback_ready(feedback_ready));

   efm_host_model i_host (.ref_clk(ref_clk), .reset_n(reset_n),
      .quad_a(quadrature_out_a), .quad_b(quadrature_out_b),
      .edge_pos(edge_pos), .bad_steps(bad_steps));

   // Free-running 10 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Four-state compare, so an unknown never passes for a match.
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Settings only count at restart, so each test begins with a reset
   // held 20 cycles and then waits, bounded, for the latch.
   task automatic restart(logic sel, logic [15:0] lim, logic [15:0] ppr,
      logic fit_inc, logic multi);
      int n;
      @(posedge ref_clk);
      #1;
      reset_n = 1'b0;
      encoder_type_select = sel;
      multiturn_wrap_limit = lim;
      feedback_pulses_per_rev = ppr;
      enc_fitted_incremental = fit_inc;
      enc_multiturn_capable = multi;
      repeat (20) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      for (n = 0; n < 20 && feedback_ready !== 1'b1; n++)
      begin
         @(posedge ref_clk);
         #1;
      end
      check("feedback_ready", {31'h0, feedback_ready}, 32'h1);
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // One encoder count is two clocks high and two low; the direction is
   // set well ahead so it is steady at the rising step.
   task automatic spin(logic dir, int n);
      enc_dir = dir;
      repeat (2) @(posedge ref_clk);
      repeat (n)
      begin
         @(posedge ref_clk);
         #1;
         enc_step = 1'b1;
         repeat (2) @(posedge ref_clk);
         #1;
         enc_step = 1'b0;
         @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
      #1;
   endtask

   // Cuts a hang short; the tests need about 7,400 cycles.
   initial
   begin
      repeat (50000) @(posedge ref_clk);
      fail_count++;
      final_report();
   end

   // Main sequence. Pulses per revolution stay at most 256 / 4 so that
   // every divided edge falls on a whole encoder count.
   initial
   begin
      fail_count = 0;
      num_checks = 0;
      reset_n = 1'b0;
      encoder_type_select = 1'b0;
      multiturn_wrap_limit = 16'h000A;
      feedback_pulses_per_rev = 16'h0010;
      enc_step = 1'b0;
      enc_dir = 1'b1;
      enc_index = 1'b0;
      enc_fitted_incremental = 1'b0;
      enc_multiturn_capable = 1'b1;

      restart(1'b0, 16'h0003, 16'h0010, 1'b0, 1'b1);
      check("absolute_mode", {31'h0, absolute_mode}, 32'h1);
      check("encoder_alarm", {31'h0, encoder_alarm}, 32'h0);
      spin(1'b1, 256);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h1);
      check("single_turn_pos", {24'h0, single_turn_pos}, 32'h0);
      check("edge_pos", edge_pos, 32'd64);
      spin(1'b1, 512);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h0);
      check("edge_pos", edge_pos, 32'd192);
      encoder_type_select = 1'b1;
      multiturn_wrap_limit = 16'h0005;
      spin(1'b0, 256);
      check("absolute_mode", {31'h0, absolute_mode}, 32'h1);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h2);
      check("edge_pos", edge_pos, 32'd128);
      check("bad_steps", bad_steps, 32'd0);
      $display("test wrap_limit done");

      restart(1'b0, 16'h000A, 16'h0010, 1'b0, 1'b1);
      spin(1'b0, 1);
      check("multiturn_count", {16'h0, multiturn_count}, 32'hFFFF);
      check("single_turn_pos", {24'h0, single_turn_pos}, 32'hFF);
      spin(1'b1, 1);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h0);
      $display("test default_limit done");

      restart(1'b1, 16'h0003, 16'h0010, 1'b1, 1'b1);
      check("absolute_mode", {31'h0, absolute_mode}, 32'h0);
      check("encoder_alarm", {31'h0, encoder_alarm}, 32'h0);
      spin(1'b1, 256);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h0);
      check("edge_pos", edge_pos, 32'd64);
      $display("test incremental done");

      // A setting below the minimum must act as 16 pulses per revolution.
      restart(1'b0, 16'h0003, 16'h0008, 1'b0, 1'b0);
      spin(1'b1, 256);
      check("multiturn_count", {16'h0, multiturn_count}, 32'h0);
      check("edge_pos", edge_pos, 32'd64);
      $display("test single_turn done");

      restart(1'b0, 16'h000A, 16'h0040, 1'b1, 1'b1);
      check("encoder_alarm", {31'h0, encoder_alarm}, 32'h1);
      spin(1'b1, 256);
      check("edge_pos", edge_pos, 32'd256);
      check("bad_steps", bad_steps, 32'd0);
      @(posedge ref_clk);
      #1;
      enc_index = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check("index_pulse_out", {31'h0, index_pulse_out}, 32'h0);
      @(posedge ref_clk);
      #1;
      check("index_pulse_out", {31'h0, index_pulse_out}, 32'h1);
      enc_index = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check("index_pulse_out", {31'h0, index_pulse_out}, 32'h0);
      check("encoder_alarm", {31'h0, encoder_alarm}, 32'h1);
      $display("test divider_index done");
      final_report();
   end
endmodule
